// File: chb_cfg.svh
// Purpose: Constants for the beacon and remote switch logic
// Assumes: 200 MHz system clock
// Notes:   Counts derived from times in their own unit
`ifndef CHB_CFG_SVH
`define CHB_CFG_SVH
`define CHB_CLK_MHZ        200
`define CHB_BEACON_MS      1000
`define CHB_BEACON_CYCLES  (`CHB_BEACON_MS * 1000 * `CHB_CLK_MHZ)
`define CHB_MARKER         8'haa
`define CHB_CMD_ON         8'h01
`define CHB_CMD_OFF        8'h00
`define CHB_CTRL_LEN       4'h1
`define CHB_STATUS_LEN     4'h8
`define CHB_SEP_MIN        8'h20
`define CHB_SEP_MAX        8'h7e
`define CHB_SEP_DEFAULT    8'h3b
`endif

// File: chb_pkg.sv
// Purpose: Shared types of the beacon block
// Assumes: Constants live in chb_cfg.svh
// Notes:   Nothing here is imported
package chb_pkg;
   typedef enum logic [0:0] {CHB_IDLE, CHB_SEND} chb_tx_state_t;
endpackage : chb_pkg

// File: chb_sep_check.sv
// Purpose: Separator code filter
// Assumes: Codes arrive as 8-bit ASCII
// Notes:   Invalid codes fall back to the default delimiter
`timescale 1ns/1ps
`include "chb_cfg.svh"
module chb_sep_check (
   input  wire logic [7:0] code_i,
   output logic      [7:0] code_o,
   output logic            valid_o
);
   always_comb begin
      valid_o = (code_i >= `CHB_SEP_MIN) && (code_i <= `CHB_SEP_MAX);
      code_o  = valid_o ? code_i : `CHB_SEP_DEFAULT;
   end
endmodule : chb_sep_check

// File: chb_beacon_ctrl.sv
// Purpose: Status beacon builder and run-time logging switch
// Assumes: A CAN controller presents received frames as one-cycle pulses
// Notes:   Record field selection is registered straight through
`timescale 1ns/1ps
`include "chb_cfg.svh"
module chb_beacon_ctrl #(
   parameter int unsigned BEACON_CYCLES = `CHB_BEACON_CYCLES
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        clk_en_i,
   input  wire logic        beacon_on_i,
   input  wire logic        beacon_long_identifier_select_i,
   input  wire logic [28:0] beacon_frame_identifier_i,
   input  wire logic        remote_switch_on_i,
   input  wire logic        ctrl_long_identifier_select_i,
   input  wire logic [28:0] ctrl_frame_identifier_i,
   input  wire logic        default_record_state_i,
   input  wire logic        silent_i,
   input  wire logic [31:0] epoch_seconds_i,
   input  wire logic [15:0] free_mb_i,
   input  wire logic [5:0]  field_include_i,
   input  wire logic [7:0]  column_delimiter_code_i,
   input  wire logic        rx_valid_i,
   input  wire logic        rx_long_i,
   input  wire logic [28:0] rx_identifier_i,
   input  wire logic [3:0]  rx_payload_length_field_i,
   input  wire logic [7:0]  rx_byte0_i,
   input  wire logic        tx_ready_i,
   output logic             tx_valid_o,
   output logic             tx_long_o,
   output logic [28:0]      tx_identifier_o,
   output logic [3:0]       tx_payload_length_field_o,
   output logic [63:0]      tx_payload_o,
   output logic             logging_on_o,
   output logic             ack_enable_o,
   output logic [5:0]       field_include_o,
   output logic [7:0]       column_delimiter_code_o,
   output logic             delimiter_bad_o
);
   typedef struct packed {
      chb_pkg::chb_tx_state_t st;
      logic [31:0]            tick;
      logic                   seen_rx;
      logic                   logging;
      logic                   loaded;
      logic                   tx_valid;
      logic                   tx_long;
      logic [28:0]            tx_id;
      logic [63:0]            tx_data;
      logic                   ack_en;
      logic [5:0]             fields;
      logic [7:0]             delim;
      logic                   delim_bad;
   } chb_state_t;

   chb_state_t state_reg;
   chb_state_t state_next;
   logic [7:0] sep_code;
   logic       sep_ok;
   logic       ctrl_hit;
   logic       ctrl_ok;

   chb_sep_check u_sep (
      .code_i  (column_delimiter_code_i),
      .code_o  (sep_code),
      .valid_o (sep_ok)
   );

   function automatic logic id_match(input logic a_long, input logic [28:0] a,
                                     input logic b_long, input logic [28:0] b);
      logic [28:0] msk;
      msk = b_long ? 29'h1fffffff : 29'h000007ff;
      id_match = (a_long == b_long) && ((a & msk) == (b & msk));
   endfunction : id_match

   always_comb begin
      ctrl_hit = rx_valid_i && remote_switch_on_i &&
         id_match(rx_long_i, rx_identifier_i,
                  ctrl_long_identifier_select_i,
                  ctrl_frame_identifier_i);
      ctrl_ok = ctrl_hit && (rx_payload_length_field_i == `CHB_CTRL_LEN) &&
         ((rx_byte0_i == `CHB_CMD_ON) || (rx_byte0_i == `CHB_CMD_OFF));
   end

   always_comb begin
      state_next = state_reg;
      state_next.ack_en    = !silent_i;
      state_next.fields    = field_include_i;
      state_next.delim     = sep_code;
      state_next.delim_bad = !sep_ok;
      if (!state_reg.loaded) begin
         state_next.logging = default_record_state_i;
         state_next.loaded  = 1'b1;
      end else if (ctrl_ok) begin
         state_next.logging = (rx_byte0_i == `CHB_CMD_ON);
      end
      if (rx_valid_i) begin
         state_next.seen_rx = 1'b1;
      end
      // Period keeps running while held off so frames stay 1 s apart
      if (state_reg.tick >= BEACON_CYCLES - 1) begin
         state_next.tick = 32'h00000000;
      end else begin
         state_next.tick = state_reg.tick + 32'h00000001;
      end
      case (state_reg.st)
         chb_pkg::CHB_IDLE: begin
            if ((state_reg.tick >= BEACON_CYCLES - 1) && beacon_on_i &&
                state_reg.seen_rx && !silent_i) begin
               state_next.st       = chb_pkg::CHB_SEND;
               state_next.tx_valid = 1'b1;
               state_next.tx_long  = beacon_long_identifier_select_i;
               state_next.tx_id    = beacon_frame_identifier_i;
               state_next.tx_data  = {`CHB_MARKER, 7'h00,
                  state_reg.logging, epoch_seconds_i, free_mb_i};
            end
         end
         chb_pkg::CHB_SEND: begin
            if (tx_ready_i) begin
               state_next.st       = chb_pkg::CHB_IDLE;
               state_next.tx_valid = 1'b0;
            end
         end
         default: begin
            state_next.st       = chb_pkg::CHB_IDLE;
            state_next.tx_valid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_reg <= '0;
      end else if (clk_en_i) begin
         state_reg <= state_next;
      end
   end

   always_comb begin
      tx_valid_o                = state_reg.tx_valid;
      tx_long_o                 = state_reg.tx_long;
      tx_identifier_o           = state_reg.tx_id;
      tx_payload_length_field_o = `CHB_STATUS_LEN;
      tx_payload_o              = state_reg.tx_data;
      logging_on_o              = state_reg.logging;
      ack_enable_o              = state_reg.ack_en;
      field_include_o           = state_reg.fields;
      column_delimiter_code_o   = state_reg.delim;
      delimiter_bad_o           = state_reg.delim_bad;
   end

   a_marker_byte: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> tx_payload_o[63:56] == 8'haa)
      else $error("marker byte wrong");
   a_state_byte: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> tx_payload_o[55:48] == {7'h00, $past(logging_on_o)})
      else $error("state byte wrong");
   a_no_silent_tx: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> !$past(silent_i))
      else $error("beacon sent in silent mode");
   a_no_off_tx: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> $past(beacon_on_i))
      else $error("beacon sent while disabled");
   a_need_rx: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> $past(state_reg.seen_rx))
      else $error("beacon before first reception");
   a_ctrl_on: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_en_i && ctrl_ok && state_reg.loaded && rx_byte0_i == 8'h01
      |=> logging_on_o)
      else $error("control on not applied");
   a_ctrl_off: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_en_i && ctrl_ok && state_reg.loaded && rx_byte0_i == 8'h00
      |=> !logging_on_o)
      else $error("control off not applied");
   a_ctrl_ignored: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_en_i && state_reg.loaded && !ctrl_ok |=> $stable(logging_on_o))
      else $error("logging changed without valid control");
   a_silent_ack: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      clk_en_i && silent_i |=> !ack_enable_o)
      else $error("ack enabled in silent mode");
   a_beacon_id: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> tx_identifier_o == $past(beacon_frame_identifier_i)
      && tx_long_o == $past(beacon_long_identifier_select_i))
      else $error("beacon identifier wrong");
   // Reset is still seen at the release edge, so that edge is skipped
   a_load_default: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !rst_i && clk_en_i && !state_reg.loaded
      |=> logging_on_o == $past(default_record_state_i))
      else $error("default logging state not loaded");
   a_field_order: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      $rose(tx_valid_o) |-> tx_payload_o[47:16] == $past(epoch_seconds_i)
      && tx_payload_o[15:0] == $past(free_mb_i))
      else $error("status fields out of order");
   a_frame_hold: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_payload_o))
      else $error("status frame dropped before acceptance");
   a_delim_range: assert property (
      @(posedge sys_clk_i) disable iff (rst_i)
      !rst_i && clk_en_i |=> column_delimiter_code_o >= 8'h20
      && column_delimiter_code_o <= 8'h7e)
      else $error("delimiter outside printable range");
endmodule : chb_beacon_ctrl

// File: chb_can_partner.sv
// Purpose: CAN controller stand-in that takes status frames
// Assumes: One frame offered at a time, held until taken
// Notes:   stall_i sets the wait before acceptance
`timescale 1ns/1ps
module chb_can_partner (
   input  wire logic        sys_clk_i,
   input  wire logic        tx_valid_i,
   input  wire logic [63:0] tx_payload_i,
   input  wire logic [7:0]  stall_i,
   output logic             tx_ready_o,
   output logic [31:0]      epoch_o,
   output logic [15:0]      free_mb_o
);
   logic [7:0] wait_reg;
   // Ready lasts one cycle so a held frame is never taken twice
   always_ff @(posedge sys_clk_i) begin
      tx_ready_o <= tx_valid_i && !tx_ready_o && wait_reg == stall_i;
      wait_reg <= (tx_valid_i && !tx_ready_o) ? wait_reg + 8'h01 : 8'h00;
      if (tx_valid_i && tx_ready_o) begin
         epoch_o   <= tx_payload_i[47:16];
         free_mb_o <= tx_payload_i[15:0];
      end
   end
endmodule : chb_can_partner

// File: test_can_heartbeat_control_frames.sv
// Purpose: Self-checking bench of the beacon and remote switch
// Assumes: Beacon period shortened to 50 cycles
// Notes:   Control frames driven as one-cycle pulses
`timescale 1ns/1ps
`include "chb_cfg.svh"
module test_can_heartbeat_control_frames;
   localparam logic [28:0] CID = 29'h00a5c3e1;
   localparam logic [28:0] BID = 29'h00000523;
   localparam logic [31:0] EP = 32'h57420156;
   localparam logic [15:0] FM = 16'h1d93;
   logic sys_clk_i = 0, rst_i = 1, b_on = 0, b_long = 1, sw_on = 1;
   logic silent = 0, rx_v = 0, rx_long = 0, tx_v, tx_long, log_on, ack_en;
   logic ready, bad_o, bad_e;
   logic clk_en = 1, c_long = 1, def_on = 0;
   logic [28:0] rx_id = '0, tx_id;
   logic [3:0]  rx_len = '0, tx_len;
   logic [7:0]  rx_b = '0, dl_i = 8'h3b, dl_o, stall = 8'h05;
   logic [5:0]  fi_i = '0, fi_o;
   logic [63:0] tx_pl;
   logic [31:0] p_ep;
   logic [15:0] p_fm;
   logic [7:0]  codes [4] = '{8'h1f, 8'h20, 8'h7e, 8'h7f};
   time t1, t2;
   int mismatches = 0, samples_checked = 0;
   chb_beacon_ctrl #(.BEACON_CYCLES(50)) DUT (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .clk_en_i(clk_en), .beacon_on_i(b_on),
      .beacon_long_identifier_select_i(b_long),
      .beacon_frame_identifier_i(BID), .remote_switch_on_i(sw_on),
      .ctrl_long_identifier_select_i(c_long), .ctrl_frame_identifier_i(CID),
      .default_record_state_i(def_on), .silent_i(silent),
      .epoch_seconds_i(EP), .free_mb_i(FM), .field_include_i(fi_i),
      .column_delimiter_code_i(dl_i), .rx_valid_i(rx_v), .rx_long_i(rx_long),
      .rx_identifier_i(rx_id), .rx_payload_length_field_i(rx_len),
      .rx_byte0_i(rx_b), .tx_ready_i(ready), .tx_valid_o(tx_v),
      .tx_long_o(tx_long), .tx_identifier_o(tx_id),
      .tx_payload_length_field_o(tx_len), .tx_payload_o(tx_pl),
      .logging_on_o(log_on), .ack_enable_o(ack_en), .field_include_o(fi_o),
      .column_delimiter_code_o(dl_o), .delimiter_bad_o(bad_o));
   chb_can_partner PEER (.sys_clk_i(sys_clk_i), .tx_valid_i(tx_v),
      .tx_payload_i(tx_pl), .stall_i(stall), .tx_ready_o(ready),
      .epoch_o(p_ep), .free_mb_o(p_fm));
   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   task automatic chk(input string w, input logic [63:0] e, input logic [63:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", w, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task automatic ctrl(input logic lg, input logic [28:0] id,
                       input logic [3:0] len, input logic [7:0] b, input logic e);
      @(posedge sys_clk_i);
      rx_v <= 1'b1;
      rx_long <= lg;
      rx_id <= id;
      rx_len <= len;
      rx_b <= b;
      @(posedge sys_clk_i);
      rx_v <= 1'b0;
      tick(1);
      chk("logging state", e, log_on);
   endtask : ctrl
   task automatic quiet(input string w, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         tick(1);
         if (tx_v !== 1'b0) bad++;
      end
      chk(w, 0, bad);
   endtask : quiet
   // Waits for a launch, then for its acceptance and release
   task automatic take_tx(output time t, input logic lg);
      int n;
      n = 0;
      while (tx_v !== 1'b1 && n < 200) begin
         tick(1);
         n++;
      end
      t = $time;
      chk("beacon seen", 1, tx_v);
      chk("length", `CHB_STATUS_LEN, tx_len);
      chk("identifier", BID, tx_id);
      chk("format", b_long, tx_long);
      chk("payload", {`CHB_MARKER, 7'h00, lg, EP, FM}, tx_pl);
      while (ready !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      tick(1);
      chk("release", 0, tx_v);
   endtask : take_tx
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   initial begin
      #(20000 * 5);
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      tick(2);
      chk("logging after reset", 0, log_on);
      chk("ack enable", 1, ack_en);
      @(posedge sys_clk_i);
      b_on <= 1'b1;
      quiet("beacon before rx", 120);
      @(posedge sys_clk_i);
      b_on <= 1'b0;
      $display("test startup done");
      ctrl(1'b1, CID, `CHB_CTRL_LEN, `CHB_CMD_ON, 1'b1);
      ctrl(1'b1, CID, 4'h2, `CHB_CMD_OFF, 1'b1);
      ctrl(1'b1, CID, `CHB_CTRL_LEN, 8'h02, 1'b1);
      ctrl(1'b0, CID, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b1);
      ctrl(1'b1, CID ^ 29'h1, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b1);
      @(posedge sys_clk_i);
      sw_on <= 1'b0;
      ctrl(1'b1, CID, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b1);
      @(posedge sys_clk_i);
      sw_on <= 1'b1;
      c_long <= 1'b0;
      ctrl(1'b1, CID, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b1);
      ctrl(1'b0, CID & 29'h7ff, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b0);
      ctrl(1'b0, CID & 29'h7ff, `CHB_CTRL_LEN, `CHB_CMD_ON, 1'b1);
      // Frozen block must not take the frame
      @(posedge sys_clk_i);
      c_long <= 1'b1;
      clk_en <= 1'b0;
      ctrl(1'b1, CID, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b1);
      @(posedge sys_clk_i);
      clk_en <= 1'b1;
      ctrl(1'b1, CID, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b0);
      $display("test control done");
      quiet("beacon disabled", 120);
      @(posedge sys_clk_i);
      b_on <= 1'b1;
      take_tx(t1, 1'b0);
      chk("decoded epoch", EP, p_ep);
      chk("decoded space", FM, p_fm);
      take_tx(t2, 1'b0);
      chk("period", 50, (t2 - t1) / 5);
      @(posedge sys_clk_i);
      b_long <= 1'b0;
      take_tx(t1, 1'b0);
      $display("test beacon done");
      @(posedge sys_clk_i);
      silent <= 1'b1;
      tick(2);
      chk("ack in silent", 0, ack_en);
      quiet("beacon in silent", 120);
      @(posedge sys_clk_i);
      silent <= 1'b0;
      $display("test silent done");
      foreach (codes[i]) begin
         @(posedge sys_clk_i);
         dl_i <= codes[i];
         fi_i <= codes[i][5:0];
         tick(2);
         bad_e = codes[i] < `CHB_SEP_MIN || codes[i] > `CHB_SEP_MAX;
         chk("delimiter flag", bad_e, bad_o);
         chk("delimiter", bad_e ? `CHB_SEP_DEFAULT : codes[i], dl_o);
         chk("include", codes[i][5:0], fi_o);
      end
      $display("test record fields done");
      // Second reset with logging on by default; reception gate re-arms
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      def_on <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      tick(2);
      chk("logging after second reset", 1, log_on);
      chk("ack after second reset", 1, ack_en);
      quiet("beacon after reset before rx", 120);
      ctrl(1'b1, CID ^ 29'h1, `CHB_CTRL_LEN, `CHB_CMD_OFF, 1'b1);
      take_tx(t1, 1'b1);
      $display("test second reset done");
      finish_test();
   end
endmodule : test_can_heartbeat_control_frames
